//--- rtl/inv_transceiver.sv
// Purpose: Eight-bit registered inverting bus transceiver
// Assumes: All pins synchronous to sys_clk; capture clocks are sampled
// Notes: Driven data and enables appear one cycle after their cause
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Each register stores its bus on its capture clock rising edge.
// - With drive enable low, direction picks which bus is driven.
// - Enable low, direction low: drive A with B-side data.
// - Enable high drives neither bus; registers still capture.
// - Each port's data is stored only in its own register: A in the A-to-B register, B in the B-to-A register.
// - Source select picks live opposite bus or stored register.
// - Never drive both buses at once.
// - Capture happens on every rising edge whatever the drive state.
// - All data reaching the driven port is inverted.
// - Buses and registers are eight bits, bit for bit.
module inv_transceiver (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Control pins
	input wire logic drive_enable_n,
	input wire logic direction,
	input wire logic a_to_b_source_select,
	input wire logic b_to_a_source_select,
	input wire logic a_to_b_capture_clock,
	input wire logic b_to_a_capture_clock,
	// A side lines
	input wire logic [xcvr_pkg::BUS_W-1:0] port_a_lines_in,
	output logic [xcvr_pkg::BUS_W-1:0] port_a_lines_out,
	output logic port_a_lines_oe,
	// B side lines
	input wire logic [xcvr_pkg::BUS_W-1:0] port_b_lines_in,
	output logic [xcvr_pkg::BUS_W-1:0] port_b_lines_out,
	output logic port_b_lines_oe,
	// Stored contents
	output logic [xcvr_pkg::BUS_W-1:0] a_to_b_stored,
	output logic [xcvr_pkg::BUS_W-1:0] b_to_a_stored,
	// Capture log stream
	output logic capture_log_valid,
	input wire logic capture_log_ready,
	output logic [xcvr_pkg::LOG_W-1:0] capture_log_data,
	output logic capture_log_in_ready,
	output logic capture_log_dropped
);
	localparam int W = xcvr_pkg::BUS_W;

	generate
		if (W != 8)
		begin : g_bad_width
			$error("inv_transceiver: bus width must be eight");
		end
	endgenerate

	logic ab_clk_prev_q, ab_clk_prev_d, ba_clk_prev_q, ba_clk_prev_d;
	logic [W-1:0] ab_reg_q, ab_reg_d, ba_reg_q, ba_reg_d;
	logic [W-1:0] a_out_q, a_out_d, b_out_q, b_out_d;
	logic a_oe_q, a_oe_d, b_oe_q, b_oe_d;
	logic dropped_q, dropped_d;
	logic ab_rise, ba_rise;

	word_stream_if #(.W(xcvr_pkg::LOG_W)) log_in ();
	word_stream_if #(.W(xcvr_pkg::LOG_W)) log_out ();

	// Inverting selector shared by both directions
	function automatic logic [W-1:0] pick_inv(input logic sel,
		input logic [W-1:0] live, input logic [W-1:0] stored);
		pick_inv = sel ? ~stored : ~live;
	endfunction

	assign ab_rise = a_to_b_capture_clock && !ab_clk_prev_q;
	assign ba_rise = b_to_a_capture_clock && !ba_clk_prev_q;

	always_comb
	begin
		ab_clk_prev_d = a_to_b_capture_clock;
		ba_clk_prev_d = b_to_a_capture_clock;
		ab_reg_d = ab_reg_q;
		ba_reg_d = ba_reg_q;
		if (ab_rise)
			ab_reg_d = port_a_lines_in;
		if (ba_rise)
			ba_reg_d = port_b_lines_in;
	end

	always_comb
	begin
		a_oe_d = 1'b0;
		b_oe_d = 1'b0;
		a_out_d = a_out_q;
		b_out_d = b_out_q;
		if (!drive_enable_n && !direction)
		begin
			a_oe_d = 1'b1;
			a_out_d = pick_inv(b_to_a_source_select, port_b_lines_in,
				ba_reg_q);
		end
		else if (!drive_enable_n)
		begin
			b_oe_d = 1'b1;
			b_out_d = pick_inv(a_to_b_source_select, port_a_lines_in,
				ab_reg_q);
		end
	end

	// Log every capture; a full log loses the word but not the capture
	assign log_in.valid = ab_rise || ba_rise;
	assign log_in.data = {ab_rise, ba_rise, port_a_lines_in, port_b_lines_in};
	assign dropped_d = dropped_q || (log_in.valid && !log_in.ready);

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			ab_clk_prev_q <= 1'b0;
			ba_clk_prev_q <= 1'b0;
			ab_reg_q <= xcvr_pkg::STORE_RST;
			ba_reg_q <= xcvr_pkg::STORE_RST;
			a_out_q <= xcvr_pkg::LINES_RST;
			b_out_q <= xcvr_pkg::LINES_RST;
			a_oe_q <= 1'b0;
			b_oe_q <= 1'b0;
			dropped_q <= 1'b0;
		end
		else
		begin
			ab_clk_prev_q <= ab_clk_prev_d;
			ba_clk_prev_q <= ba_clk_prev_d;
			ab_reg_q <= ab_reg_d;
			ba_reg_q <= ba_reg_d;
			a_out_q <= a_out_d;
			b_out_q <= b_out_d;
			a_oe_q <= a_oe_d;
			b_oe_q <= b_oe_d;
			dropped_q <= dropped_d;
		end
	end

	capture_log_fifo #(
		.W(xcvr_pkg::LOG_W),
		.DEPTH(xcvr_pkg::LOG_DEPTH)
	) u_log (
		.sys_clk(sys_clk),
		.rst(rst),
		.fill(log_in.snk),
		.drain(log_out.src)
	);

	assign log_out.ready = capture_log_ready;
	assign capture_log_valid = log_out.valid;
	assign capture_log_data = log_out.data;
	assign capture_log_in_ready = log_in.ready;
	assign capture_log_dropped = dropped_q;
	assign port_a_lines_out = a_out_q;
	assign port_b_lines_out = b_out_q;
	assign port_a_lines_oe = a_oe_q;
	assign port_b_lines_oe = b_oe_q;
	assign a_to_b_stored = ab_reg_q;
	assign b_to_a_stored = ba_reg_q;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	AST_AB_CAPTURE: assert property (
		ab_rise |=> ab_reg_q == $past(port_a_lines_in))
		else $error("A register missed its capture edge");
	AST_BA_HOLD: assert property (
		!ba_rise |=> ba_reg_q == $past(ba_reg_q))
		else $error("B register changed without its own edge");
	AST_DRIVE_A: assert property (
		!drive_enable_n && !direction |=> port_a_lines_oe && !port_b_lines_oe)
		else $error("A port not driven for direction low");
	AST_DRIVE_B: assert property (
		!drive_enable_n && direction |=> port_b_lines_oe && !port_a_lines_oe)
		else $error("B port not driven for direction high");
	AST_ISOLATE: assert property (
		drive_enable_n |=> !port_a_lines_oe && !port_b_lines_oe)
		else $error("bus driven while drive enable high");
	AST_CAPTURE_WHILE_DRIVING: assert property (
		!drive_enable_n && ba_rise |=> ba_reg_q == $past(port_b_lines_in))
		else $error("B capture lost while driving");
	AST_STORED_TO_A: assert property (
		!drive_enable_n && !direction && b_to_a_source_select
		|=> port_a_lines_out == ~$past(ba_reg_q))
		else $error("A port not showing inverted stored data");
	AST_LIVE_TO_B: assert property (
		!drive_enable_n && direction && !a_to_b_source_select
		|=> port_b_lines_out == ~$past(port_a_lines_in))
		else $error("B port not showing inverted live data");
	AST_STORED_TO_B: assert property (
		!drive_enable_n && direction && a_to_b_source_select
		|=> port_b_lines_out == ~$past(ab_reg_q))
		else $error("B port not showing inverted stored data");
	AST_ONE_DRIVER: assert property (
		!(port_a_lines_oe && port_b_lines_oe))
		else $error("both buses driven");
	AST_DROP_STICKY: assert property (
		ab_rise && !capture_log_in_ready |=> capture_log_dropped [*2])
		else $error("lost log word not flagged");

	COV_ISO_CAPTURE: cover property (drive_enable_n && ab_rise && ba_rise);
	COV_STORED_B: cover property (
		!drive_enable_n && direction && a_to_b_source_select ##1 ab_rise);
	COV_LOG_FULL: cover property (!capture_log_in_ready);
endmodule // inv_transceiver
`default_nettype wire

//--- inc/xcvr_pkg.sv
// Purpose: Shared constants for the registered inverting transceiver
// Assumes: One system clock, synchronous active-high reset
// Notes: Capture log word is {ab_hit, ba_hit, ab_data, ba_data}
package xcvr_pkg;
	localparam int BUS_W = 8;
	localparam int LOG_DEPTH = 8;
	localparam int LOG_W = 2 + 2 * BUS_W;
	localparam int LOG_AB_HIT_POS = LOG_W - 1;
	localparam int LOG_BA_HIT_POS = LOG_W - 2;
	localparam int LOG_AB_DATA_LSB = BUS_W;
	localparam int LOG_BA_DATA_LSB = 0;
	localparam logic [BUS_W-1:0] STORE_RST = 8'h00;
	localparam logic [BUS_W-1:0] LINES_RST = 8'h00;
endpackage

//--- inc/word_stream_if.sv
// Purpose: Valid/ready word stream between the transceiver and its log
// Assumes: Word taken on a clock edge where valid and ready are both high
// Notes: src drives the word, snk accepts it
`timescale 1ns/1ps
`default_nettype none
interface word_stream_if #(parameter int W = 18);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

//--- rtl/capture_log_fifo.sv
// Purpose: Flip-flop FIFO for captured words
// Assumes: Depth is a power of two, at least two
// Notes: Full and empty are exact; no write while full
`timescale 1ns/1ps
`default_nettype none
module capture_log_fifo #(
	parameter int W = 18,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Fill and drain sides
	word_stream_if.snk fill,
	word_stream_if.src drain
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

	generate
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
		begin : g_bad_depth
			$error("capture_log_fifo: DEPTH must be a power of two >= 2");
		end
	endgenerate

	logic [W-1:0] mem_q [DEPTH];
	logic [W-1:0] mem_d [DEPTH];
	logic [AW-1:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
	logic [AW:0] count_q, count_d;
	logic push, pop;

	assign fill.ready = (count_q != FULL_CNT);
	assign drain.valid = (count_q != '0);
	assign drain.data = mem_q[rd_ptr_q];
	assign push = fill.valid && fill.ready;
	assign pop = drain.valid && drain.ready;

	always_comb
	begin
		mem_d = mem_q;
		wr_ptr_d = wr_ptr_q;
		rd_ptr_d = rd_ptr_q;
		count_d = count_q;
		if (push)
		begin
			mem_d[wr_ptr_q] = fill.data;
			wr_ptr_d = wr_ptr_q + 1'b1;
		end
		if (pop)
			rd_ptr_d = rd_ptr_q + 1'b1;
		if (push && !pop)
			count_d = count_q + 1'b1;
		else if (pop && !push)
			count_d = count_q - 1'b1;
	end

	// Storage is not reset; only pointers matter
	always_ff @(posedge sys_clk)
	begin
		mem_q <= mem_d;
		if (rst)
		begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
		end
		else
		begin
			wr_ptr_q <= wr_ptr_d;
			rd_ptr_q <= rd_ptr_d;
			count_q <= count_d;
		end
	end

	AST_NO_OVERRUN: assert property (@(posedge sys_clk) disable iff (rst)
		count_q == FULL_CNT && !pop |=> count_q == FULL_CNT)
		else $error("fifo count changed while full without a pop");
endmodule // capture_log_fifo
`default_nettype wire

//--- tb/bus_partner.sv
// Purpose: Far-side buses and log consumer
// Assumes: Partner drives a bus only while the block does not
// Notes: Log ready is simply the inverse of the stall input
`timescale 1ns/1ps
`default_nettype none
module bus_partner (
	// Block side
	input wire logic [7:0] a_out,
	input wire logic a_oe,
	input wire logic [7:0] b_out,
	input wire logic b_oe,
	// Bench side
	input wire logic [7:0] a_val,
	input wire logic [7:0] b_val,
	input wire logic stall,
	// Resolved lines
	output logic [7:0] a_wire,
	output logic [7:0] b_wire,
	output logic log_ready
);
	// Release on oe, never a fight
	assign a_wire = a_oe ? a_out : a_val;
	assign b_wire = b_oe ? b_out : b_val;
	assign log_ready = !stall;
endmodule // bus_partner
`default_nettype wire

//--- tb/tb_inv_transceiver.sv
// Purpose: Self-checking bench for the inverting transceiver
// Assumes: One-cycle latency, capture clocks sampled
// Notes: Driver queues notes, monitor compares
`timescale 1ns/1ps
`default_nettype none
module tb_inv_transceiver;
	typedef struct {
		time t;
		logic [7:0] ao, bo, sab, sba;
		logic aoe, boe, inr;
	} note_t;
	logic sys_clk = 0;
	logic rst = 1;
	logic en_n = 1, dir = 0, s_ab = 0, s_ba = 0, c_ab = 0, c_ba = 0;
	logic [7:0] a_val = 0, b_val = 0, a_w, b_w, a_o, b_o, st_ab, st_ba;
	logic a_oe, b_oe, lv, lr, stall = 1, in_r, drp;
	logic [17:0] ld, le;
	logic [16:0] r = 17'h12a7b;
	logic [7:0] m_ao = 0, m_bo = 0, m_sab = 0, m_sba = 0;
	logic m_aoe = 0, m_boe = 0, m_lca = 0, m_lcb = 0, m_drp = 0;
	note_t q[$];
	note_t n;
	logic [17:0] lq[$];
	int fails = 0, tests_run = 0, cnt = 0;
	always #25 sys_clk = ~sys_clk;
	inv_transceiver inv_transceiver_inst (.sys_clk(sys_clk), .rst(rst),
		.drive_enable_n(en_n), .direction(dir),
		.a_to_b_source_select(s_ab), .b_to_a_source_select(s_ba),
		.a_to_b_capture_clock(c_ab), .b_to_a_capture_clock(c_ba),
		.port_a_lines_in(a_w), .port_a_lines_out(a_o), .port_a_lines_oe(a_oe),
		.port_b_lines_in(b_w), .port_b_lines_out(b_o), .port_b_lines_oe(b_oe),
		.a_to_b_stored(st_ab), .b_to_a_stored(st_ba),
		.capture_log_valid(lv), .capture_log_ready(lr),
		.capture_log_data(ld), .capture_log_in_ready(in_r),
		.capture_log_dropped(drp));
	bus_partner bus_partner_inst (.a_out(a_o), .a_oe(a_oe), .b_out(b_o),
		.b_oe(b_oe), .a_val(a_val), .b_val(b_val), .stall(stall),
		.a_wire(a_w), .b_wire(b_w), .log_ready(lr));
	function automatic logic [16:0] nxt(logic [16:0] x);
		return {x[15:0], x[16] ^ x[13]};
	endfunction
	function automatic logic [17:0] lm(logic [17:0] e);
		return {2'h3, {8{e[17]}}, {8{e[16]}}};
	endfunction
	task automatic chk(string s, logic [17:0] e, logic [17:0] v);
		tests_run++;
		if (v !== e)
		begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", s, e, v);
		end
	endtask
	// Control word is {en_n, dir, s_ab, s_ba, c_ab, c_ba}
	task automatic step(logic [5:0] c, logic [7:0] a, logic [7:0] b);
		logic [7:0] aw;
		logic [7:0] bw;
		logic [1:0] hit;
		@(posedge sys_clk);
		{en_n, dir, s_ab, s_ba, c_ab, c_ba} <= c;
		a_val <= a;
		b_val <= b;
		aw = m_aoe ? m_ao : a;
		bw = m_boe ? m_bo : b;
		hit = {c[1] & !m_lca, c[0] & !m_lcb};
		m_lca = c[1];
		m_lcb = c[0];
		m_aoe = !c[5] && !c[4];
		m_boe = !c[5] && c[4];
		// Stored select sees the old register
		if (m_aoe) m_ao = ~(c[2] ? m_sba : bw);
		if (m_boe) m_bo = ~(c[3] ? m_sab : aw);
		if (hit[1]) m_sab = aw;
		if (hit[0]) m_sba = bw;
		if (hit != 2'h0 && cnt == 8) m_drp = 1'b1;
		if (hit != 2'h0 && cnt < 8)
		begin
			lq.push_back({hit, aw, bw});
			if (stall) cnt++;
		end
		q.push_back('{$time, m_ao, m_bo, m_sab, m_sba, m_aoe, m_boe, cnt < 8});
	endtask
	always @(negedge sys_clk)
	begin
		while (q.size() > 0 && q[0].t <= $time - 75)
		begin
			n = q.pop_front();
			chk("a_oe", n.aoe, a_oe);
			chk("b_oe", n.boe, b_oe);
			if (n.aoe) chk("a_out", n.ao, a_o);
			if (n.boe) chk("b_out", n.bo, b_o);
			chk("ab_reg", n.sab, st_ab);
			chk("ba_reg", n.sba, st_ba);
			chk("in_ready", n.inr, in_r);
		end
		if (lv === 1'b1 && lr === 1'b1)
		begin
			le = lq.size() > 0 ? lq.pop_front() : 18'h0;
			chk("log_word", le & lm(le), ld & lm(le));
		end
	end
	task automatic print_verdict();
		$display("fails %0d tests_run %0d", fails, tests_run);
		if (fails == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Generous span; the run needs under 500 cycles
	initial
	begin
		#100000;
		fails++;
		print_verdict();
	end
	initial
	begin
		repeat (10) @(posedge sys_clk);
		rst <= 1'b0;
		// Isolation captures until the log refuses
		for (int i = 0; i < 10; i++)
		begin
			r = nxt(nxt(r));
			step(6'h23, r[7:0], r[15:8]);
			step(6'h20, ~r[7:0], ~r[15:8]);
		end
		// Drain with the far side stalling
		repeat (60)
		begin
			@(posedge sys_clk);
			r = nxt(r);
			stall <= r[0];
		end
		stall <= 1'b0;
		repeat (3) @(posedge sys_clk);
		// Look between edges, never in the launching time step
		@(negedge sys_clk);
		cnt = 0;
		chk("log_empty", 18'h0, {17'h0, lv});
		chk("dropped", {17'h0, m_drp}, {17'h0, drp});
		// Every mode, back to back, random data and clocks
		for (int i = 0; i < 256; i++)
		begin
			r = nxt(nxt(r));
			step({i[7:4], r[1:0]}, r[9:2], r[16:9]);
		end
		// Mid-run reset; clocks low so release is not an edge
		step(6'h20, 8'h00, 8'h00);
		repeat (2) @(posedge sys_clk);
		rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		@(negedge sys_clk);
		chk("rst_ab_reg", 18'h0, {10'h0, st_ab});
		chk("rst_ba_reg", 18'h0, {10'h0, st_ba});
		chk("rst_oe", 18'h0, {16'h0, a_oe, b_oe});
		chk("rst_outs", 18'h0, {2'h0, a_o, b_o});
		chk("rst_dropped", 18'h0, {17'h0, drp});
		chk("rst_log", 18'h1, {16'h0, lv, in_r});
		repeat (2) @(posedge sys_clk);
		print_verdict();
	end
endmodule // tb_inv_transceiver
`default_nettype wire
